// >>> audio_xport_pkg.sv
// ============================================================
// shared constants for the audio input transport
package audio_xport_pkg;

  // sample path geometry
  localparam int SAMPLE_W       = 32;   // widest sample kept per slot
  localparam int LANE_CNT       = 4;    // serial audio data inputs
  localparam int LANE_W         = 2;
  localparam int CHAN_W         = 3;    // up to eight multiplexed channels
  localparam int ITEM_W         = SAMPLE_W + LANE_W + CHAN_W;
  localparam int FIFO_DEPTH     = 16;

  // multiplexed frame layout
  localparam int TDM_FRAME_BITS = 256;  // bit clocks per word-select period
  localparam int TDM_POS_W      = 8;
  localparam int TDM_SH_EIGHT   = 5;    // 32-bit slots, eight channels
  localparam int TDM_SH_FOUR    = 6;    // 64-bit slots, four channels

  // timing
  localparam int CLK_SYS_HZ     = 125_000_000;
  localparam int BCLK_MIN_HZ    = 1_000_000;
  localparam int BCLK_GAP_CYC   = (CLK_SYS_HZ + BCLK_MIN_HZ - 1) / BCLK_MIN_HZ;
  localparam int GAP_W          = 8;

  // lane masks
  localparam logic [3:0] LANES_A    = 4'h1;
  localparam logic [3:0] LANES_AB   = 4'h3;
  localparam logic [3:0] LANES_ALL  = 4'hF;

  // transport selection
  typedef enum logic {XPORT_ISLAND, XPORT_FRAME} xport_mode_t;

  // reset values
  localparam xport_mode_t MODE_RST  = XPORT_ISLAND;
  localparam logic [3:0]  LANES_RST = 4'h1;

endpackage : audio_xport_pkg

// >>> audio_xport_tx.sv
`timescale 1ns/1ps

// ============================================================
// one serial data lane: shift register closed at word boundaries
module audio_lane #(
  parameter int SAMPLE_W = 32
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  wire logic                step_i,
  input  wire logic                data_i,
  input  wire logic                close_i,
  output logic [SAMPLE_W-1:0]      word_o,
  output logic                     done_o
);
  localparam int CW = $clog2(SAMPLE_W) + 1;
  localparam logic [CW-1:0] FULL = CW'(SAMPLE_W);

  logic [SAMPLE_W-1:0] shift_r, shift_nxt, word_r, word_nxt, grown;
  logic [CW-1:0]       cnt_r, cnt_nxt;
  logic                done_r, done_nxt;

  // msb first; bits past the sample width are dropped
  always_comb begin
    grown     = (cnt_r < FULL) ? {shift_r[SAMPLE_W-2:0], data_i} : shift_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    word_nxt  = word_r;
    done_nxt  = 1'b0;
    if (step_i) begin
      if (close_i) begin
        word_nxt  = grown;
        done_nxt  = 1'b1;
        shift_nxt = '0;
        cnt_nxt   = '0;
      end else begin
        shift_nxt = grown;
        cnt_nxt   = (cnt_r < FULL) ? cnt_r + 1'b1 : cnt_r;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      shift_r <= '0;
      cnt_r   <= '0;
      word_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      word_r  <= word_nxt;
      done_r  <= done_nxt;
    end
  end

  assign word_o = word_r;
  assign done_o = done_r;
endmodule : audio_lane

// ============================================================
// synchronous fifo with valid/ready on both sides
module audio_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULLC = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // pointer and fill bookkeeping
  always_comb begin
    push    = in_valid_i && (cnt_r != FULLC);
    pop     = out_ready_i && (cnt_r != '0);
    wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt  = pop  ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  assign in_ready_o  = (cnt_r != FULLC);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
endmodule : audio_fifo

// ============================================================
// audio input transport toward the serial link
module audio_xport_tx (
  input  wire logic                                clk_sys_i,
  input  wire logic                                rst_n_i,
  input  wire logic                                audio_bit_clk_i,
  input  wire logic                                audio_word_select_i,
  input  wire logic                                audio_data_in_a_i,
  input  wire logic                                audio_data_in_b_i,
  input  wire logic                                audio_data_in_c_i,
  input  wire logic                                audio_data_in_d_i,
  input  wire logic                                island_off_i,
  input  wire logic                                surround_en_i,
  input  wire logic                                legacy_partner_i,
  input  wire logic                                repeater_en_i,
  input  wire logic                                tree_surround_i,
  input  wire logic                                dual_ab_en_i,
  input  wire logic                                tdm_en_i,
  input  wire logic                                tdm_eight_ch_i,
  input  wire logic                                video_blank_i,
  input  wire logic                                link_ready_i,
  output logic                                     link_valid_o,
  output logic [audio_xport_pkg::SAMPLE_W-1:0]     link_sample_o,
  output logic [audio_xport_pkg::LANE_W-1:0]       link_lane_o,
  output logic [audio_xport_pkg::CHAN_W-1:0]       link_chan_o,
  output logic                                     link_island_o,
  output logic                                     surround_active_o,
  output logic                                     audio_active_o,
  output logic                                     overrun_o
);
  import audio_xport_pkg::*;

  // ============================================================
  // input capture and bit clock edge
  logic                 bclk_q_r, bclk_d_r, ws_q_r, ws_d_r;
  logic [3:0]           dat_q_r;
  logic [TDM_POS_W-1:0] pos_r, pos_nxt;
  logic [GAP_W-1:0]     gap_r, gap_nxt;
  logic                 ws_d_nxt, step, close, active_r, active_nxt;
  logic [CHAN_W-1:0]    chan;

  assign step = bclk_q_r && !bclk_d_r;

  // word boundary, bit position in the multiplexed frame, clock watchdog
  always_comb begin
    ws_d_nxt   = step ? ws_q_r : ws_d_r;
    pos_nxt    = pos_r;
    if (step) begin
      pos_nxt = (ws_q_r && !ws_d_r) ? '0 : pos_r + 1'b1;
    end
    if (tdm_en_i) begin
      close = tdm_eight_ch_i ? (pos_nxt[TDM_SH_EIGHT-1:0] == '0)
                             : (pos_nxt[TDM_SH_FOUR-1:0] == '0);
      chan  = tdm_eight_ch_i ? CHAN_W'((pos_nxt - 1'b1) >> TDM_SH_EIGHT)
                             : CHAN_W'((pos_nxt - 1'b1) >> TDM_SH_FOUR);
    end else begin
      close = (ws_q_r != ws_d_r);
      chan  = {{(CHAN_W-1){1'b0}}, ws_d_r}; // select low is the first channel
    end
    gap_nxt    = step ? '0 : ((gap_r == GAP_W'(BCLK_GAP_CYC)) ? gap_r : gap_r + 1'b1);
    active_nxt = (gap_nxt != GAP_W'(BCLK_GAP_CYC));
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bclk_q_r <= 1'b0;
      bclk_d_r <= 1'b0;
      ws_q_r   <= 1'b0;
      ws_d_r   <= 1'b0;
      dat_q_r  <= '0;
      pos_r    <= '0;
      gap_r    <= GAP_W'(BCLK_GAP_CYC); // start idle: no false activity after reset
      active_r <= 1'b0;
    end else begin
      bclk_q_r <= audio_bit_clk_i;
      bclk_d_r <= bclk_q_r;
      ws_q_r   <= audio_word_select_i;
      ws_d_r   <= ws_d_nxt;
      dat_q_r  <= {audio_data_in_d_i, audio_data_in_c_i, audio_data_in_b_i, audio_data_in_a_i};
      pos_r    <= pos_nxt;
      gap_r    <= gap_nxt;
      active_r <= active_nxt;
    end
  end

  // ============================================================
  // transport mode and lane selection
  xport_mode_t mode_r, mode_nxt;
  logic [3:0]  lanes_r, lanes_nxt;
  logic        surr_r, surr_nxt, tree_surr;

  always_comb begin
    tree_surr = repeater_en_i && tree_surround_i;
    surr_nxt  = !legacy_partner_i && (surround_en_i || tree_surr) &&
                (!island_off_i || tree_surr);
    mode_nxt  = (island_off_i && !surr_nxt) ? XPORT_FRAME : XPORT_ISLAND;
    if (tdm_en_i) begin
      lanes_nxt = LANES_A;
    end else if (mode_nxt == XPORT_FRAME) begin
      lanes_nxt = legacy_partner_i ? LANES_AB : LANES_A;
    end else if (surr_nxt) begin
      lanes_nxt = LANES_ALL;
    end else begin
      lanes_nxt = dual_ab_en_i ? LANES_AB : LANES_A;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_r  <= MODE_RST;
      lanes_r <= LANES_RST;
      surr_r  <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      lanes_r <= lanes_nxt;
      surr_r  <= surr_nxt;
    end
  end

  // ============================================================
  // lanes and per-lane holding slots
  logic [SAMPLE_W-1:0] word   [LANE_CNT];
  logic [LANE_CNT-1:0] done;
  logic [SAMPLE_W-1:0] hold_r [LANE_CNT];
  logic [CHAN_W-1:0]   hch_r  [LANE_CNT];
  logic [CHAN_W-1:0]   chan_r;
  logic [LANE_CNT-1:0] pend_r, pend_nxt, take;
  logic [LANE_W-1:0]   sel;
  logic                fifo_ready, ovr_r, ovr_nxt;

  for (genvar g = 0; g < LANE_CNT; g++) begin : g_lane
    audio_lane #(.SAMPLE_W(SAMPLE_W)) u_lane (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .step_i    (step),
      .data_i    (dat_q_r[g]),
      .close_i   (close),
      .word_o    (word[g]),
      .done_o    (done[g])
    );
  end

  // lowest pending lane is pushed first; a new word beats the clear
  always_comb begin
    sel = '0;
    for (int i = LANE_CNT - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        sel = LANE_W'(i);
      end
    end
    take     = (|pend_r && fifo_ready) ? (LANE_CNT'(1) << sel) : '0;
    pend_nxt = (pend_r & ~take) | (done & lanes_r);
    ovr_nxt  = ovr_r || |(done & lanes_r & pend_r & ~take);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pend_r <= '0;
      ovr_r  <= 1'b0;
      chan_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      ovr_r  <= ovr_nxt;
      chan_r <= (step && close) ? chan : chan_r;
    end
  end

  // holding slots load when a lane closes a word
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < LANE_CNT; i++) begin
      if (done[i]) begin
        hold_r[i] <= word[i];
        hch_r[i]  <= chan_r;
      end
    end
  end

  // ============================================================
  // fifo and link output stage
  logic              f_valid, f_ready;
  logic [ITEM_W-1:0] f_data;
  logic              lv_r, lv_nxt, li_r, li_nxt;
  logic [ITEM_W-1:0] ld_r, ld_nxt;

  audio_fifo #(.WIDTH(ITEM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (|pend_r),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({hold_r[sel], sel, hch_r[sel]}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // island words only leave during blanking; the link stalls the fifo
  always_comb begin
    f_ready = (!lv_r || link_ready_i) && (mode_r == XPORT_FRAME || video_blank_i);
    lv_nxt  = lv_r && !link_ready_i;
    ld_nxt  = ld_r;
    li_nxt  = li_r;
    if (f_ready && f_valid) begin
      lv_nxt = 1'b1;
      ld_nxt = f_data;
      li_nxt = (mode_r == XPORT_ISLAND);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lv_r <= 1'b0;
      ld_r <= '0;
      li_r <= 1'b0;
    end else begin
      lv_r <= lv_nxt;
      ld_r <= ld_nxt;
      li_r <= li_nxt;
    end
  end

  assign link_valid_o      = lv_r;
  assign link_sample_o     = ld_r[ITEM_W-1 -: SAMPLE_W];
  assign link_lane_o       = ld_r[CHAN_W +: LANE_W];
  assign link_chan_o       = ld_r[CHAN_W-1:0];
  assign link_island_o     = li_r;
  assign surround_active_o = surr_r;
  assign audio_active_o    = active_r;
  assign overrun_o         = ovr_r;

  // ============================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence bit_rise_s;
    bclk_q_r && !bclk_d_r;
  endsequence
  sequence word_close_s;
    bit_rise_s ##0 close;
  endsequence

  lane_close_edge_a: assert property (|done |-> $past(step))
    else $error("lane word closed without a bit clock rise");
  word_to_slot_a: assert property (word_close_s ##1 (|(done & lanes_r)) |=> |pend_r)
    else $error("closed word did not reach a holding slot");
  island_blank_a: assert property ($rose(lv_r) && li_r |-> $past(video_blank_i))
    else $error("island word sent outside blanking");
  frame_lane_a: assert property (
    island_off_i && !tree_surr && !legacy_partner_i && !tdm_en_i
    |=> lanes_r == LANES_A && mode_r == XPORT_FRAME)
    else $error("frame transport to current partner not input A only");
  legacy_lane_a: assert property (
    island_off_i && legacy_partner_i && !tdm_en_i
    |=> lanes_r == LANES_AB && mode_r == XPORT_FRAME)
    else $error("legacy frame transport not inputs A and B");
  surround_island_a: assert property (surr_r |-> mode_r == XPORT_ISLAND)
    else $error("surround active outside island transport");
  surround_legacy_a: assert property (legacy_partner_i |=> !surr_r)
    else $error("surround used with legacy partner");
  default_island_a: assert property (!island_off_i |=> mode_r == XPORT_ISLAND)
    else $error("default transport is not island");
  tree_surround_a: assert property (
    tree_surr && !legacy_partner_i
    |=> surr_r && mode_r == XPORT_ISLAND)
    else $error("tree surround did not configure island surround");
  tdm_four_a: assert property (
    step && close && tdm_en_i && !tdm_eight_ch_i
    |-> chan < CHAN_W'(4))
    else $error("four-slot frame produced channel above three");
  link_hold_a: assert property (lv_r && !link_ready_i |=> lv_r && $stable(ld_r))
    else $error("link word changed while stalled");
endmodule : audio_xport_tx

// >>> audio_src_model.sv
`timescale 1ns/1ps

// ============================================================
// host audio source: bit clock, word select and four data lanes
module audio_src_model (
  input  wire logic       clk_sys_i,
  output logic            bclk_o,
  output logic            ws_o,
  output logic [3:0]      data_o
);

  // clock stands low and lines idle until a frame is asked for
  initial begin
    bclk_o = 1'b0;
    ws_o   = 1'b0;
    data_o = 4'h0;
  end

  // one bit slot; hp of 5..62 keeps the bit clock in 1..12.5 MHz
  task automatic put_bit(input int hp, input logic ws, input logic [3:0] d);
    bclk_o = 1'b0;
    ws_o   = ws;
    data_o = d;
    repeat (hp) @(negedge clk_sys_i);
    bclk_o = 1'b1;
    repeat (hp) @(negedge clk_sys_i);
  endtask : put_bit

  // data lines show the inverse of their last value, select holds, clock stops
  task automatic go_idle();
    @(negedge clk_sys_i);
    bclk_o = 1'b0;
    data_o = ~data_o;
  endtask : go_idle

  // two-channel frame, w bits a channel, lane l channel c at d[(2l+c)*32]
  // msb first, channel 0 while select is low, select flips at the lsb
  task automatic i2s_frame(input int w, input int hp, input logic [255:0] d);
    int         ch;
    int         b;
    logic [3:0] v;
    @(negedge clk_sys_i);
    for (int k = 0; k < 2 * w; k++) begin
      ch = k / w;
      b  = w - 1 - (k % w);
      for (int l = 0; l < 4; l++) begin
        v[l] = d[(l * 2 + ch) * 32 + b];
      end
      put_bit(hp, (ch == 0) ? (k == w - 1) : (k != 2 * w - 1), v);
    end
    go_idle();
  endtask : i2s_frame

  // 256-bit multiplexed frame on lane a; select rises at the last lsb
  task automatic tdm_frame(input int hp, input logic [255:0] fr);
    @(negedge clk_sys_i);
    put_bit(hp, 1'b0, 4'h0);  // zero lead-in: the select rise flushes it as one word
    put_bit(hp, 1'b1, 4'h0);
    for (int j = 1; j <= 256; j++) begin
      put_bit(hp, j == 256, {~data_o[3:1], fr[256 - j]});
    end
    go_idle();
    ws_o = 1'b0;
  endtask : tdm_frame

endmodule : audio_src_model

// >>> test_serializer_audio_input_transport.sv
`timescale 1ns/1ps

// ============================================================
// self-checking bench for the audio input transport
module test_serializer_audio_input_transport;
  import audio_xport_pkg::*;

  logic                clk, rst_n, bclk, ws, blank, ready, lv, isl_o, sur_o, act_o, ovr_o;
  logic [3:0]          sd;
  logic                island_off, surround_en, legacy, repeater, tree_sur, dual_ab;
  logic                tdm_en, tdm_eight, stall, blank_force, blank_val;
  logic [SAMPLE_W-1:0] smp;
  logic [LANE_W-1:0]   lane;
  logic [CHAN_W-1:0]   chan;
  logic [ITEM_W:0]     exp_q[$];
  logic [ITEM_W:0]     rx_q[$];
  logic [255:0]        fr;
  logic [5:0]          cfg;
  logic [5:0]          modes [9] = '{6'h00, 6'h08, 6'h01, 6'h05, 6'h02, 6'h03, 6'h06, 6'h19, 6'h20};
  int                  wtab  [3] = '{32, 24, 16};
  int                  fails, n_tests;

  audio_xport_tx dut_u (
    .clk_sys_i(clk), .rst_n_i(rst_n), .audio_bit_clk_i(bclk), .audio_word_select_i(ws),
    .audio_data_in_a_i(sd[0]), .audio_data_in_b_i(sd[1]), .audio_data_in_c_i(sd[2]),
    .audio_data_in_d_i(sd[3]), .island_off_i(island_off), .surround_en_i(surround_en),
    .legacy_partner_i(legacy), .repeater_en_i(repeater), .tree_surround_i(tree_sur),
    .dual_ab_en_i(dual_ab), .tdm_en_i(tdm_en), .tdm_eight_ch_i(tdm_eight),
    .video_blank_i(blank), .link_ready_i(ready), .link_valid_o(lv), .link_sample_o(smp),
    .link_lane_o(lane), .link_chan_o(chan), .link_island_o(isl_o),
    .surround_active_o(sur_o), .audio_active_o(act_o), .overrun_o(ovr_o)
  );

  audio_src_model src_u (.clk_sys_i(clk), .bclk_o(bclk), .ws_o(ws), .data_o(sd));

  // ============================================================
  // clock, link stalls and blanking drawn at the falling edge
  always #4 clk = ~clk;

  always @(negedge clk) begin
    ready <= stall ? 1'b0 : ($urandom_range(3) != 0);
    blank <= blank_force ? blank_val : ($urandom_range(7) != 0);
  end

  // words taken by the link
  always @(posedge clk) begin
    if (rst_n === 1'b1 && lv === 1'b1 && ready === 1'b1) begin
      rx_q.push_back({smp, lane, chan, isl_o});
    end
  end

  // ============================================================
  // expectation: {surround, island, lane mask} for a mode vector
  // mode bits: dual_ab, tree surround, repeater, legacy, surround, island off
  function automatic logic [5:0] exp_cfg(input logic [5:0] m);
    logic tree;
    logic sur;
    logic isl;
    tree = m[4] & m[3] & !m[2];
    sur  = tree | (m[1] & !m[0] & !m[2]);
    isl  = tree | !m[0];
    return {sur, isl, sur ? 4'hF : (isl ? (m[5] ? 4'h3 : 4'h1) : (m[2] ? 4'h3 : 4'h1))};
  endfunction : exp_cfg

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    check("reset_outputs", {lv, sur_o, act_o, ovr_o, isl_o}, 64'h0);
    rst_n = 1'b1;
    exp_q.delete();
    rx_q.delete();
  endtask : do_reset

  task automatic set_mode(input logic [5:0] m);
    @(negedge clk);
    {dual_ab, tree_sur, repeater, legacy, surround_en, island_off} = m;
  endtask : set_mode

  // one random two-channel frame, expected words queued lane-first per channel
  task automatic run_i2s(input logic [5:0] m, input int w);
    logic [255:0] d;
    logic [5:0]   c;
    c = exp_cfg(m);
    for (int i = 0; i < 8; i++) begin
      d[i * 32 +: 32] = $urandom() & ((w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1));
    end
    for (int ch = 0; ch < 2; ch++) begin
      for (int l = 0; l < 4; l++) begin
        if (c[l]) exp_q.push_back({d[(l * 2 + ch) * 32 +: 32], 2'(l), 3'(ch), c[4]});
      end
    end
    src_u.i2s_frame(w, $urandom_range(12, 5), d);
  endtask : run_i2s

  task automatic drain(input logic [5:0] c);
    int n;
    n = 0;
    while (rx_q.size() < exp_q.size() && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(negedge clk);
    check("word_count", rx_q.size(), exp_q.size());
    while (exp_q.size() > 0 && rx_q.size() > 0) begin
      check("link_word", rx_q.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
    rx_q.delete();
    check("surround_active", sur_o, c[5]);
  endtask : drain

  // ============================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {dual_ab, tree_sur, repeater, legacy, surround_en, island_off} = 6'h00;
    {tdm_en, tdm_eight, stall, blank_force, blank_val} = 5'h00;
    ready = 1'b0;
    blank = 1'b0;
    fails = 0;
    n_tests = 0;
    void'($urandom(32'hcafb));
    do_reset();
    // every transport mode; frame mode runs with blanking held low
    // modes cover: default repeater frame legacy
    // surround legacy surround tree surround dual lanes
    for (int i = 0; i < 9; i++) begin
      set_mode(modes[i]);
      cfg = exp_cfg(modes[i]);
      blank_force = !cfg[4];
      blank_val = 1'b0;
      repeat (2) run_i2s(modes[i], wtab[i % 3]);
      @(negedge clk);
      check("audio_active", act_o, 1'b1);
      drain(cfg);
    end
    repeat (200) @(negedge clk);
    check("audio_idle", act_o, 1'b0);
    // island words wait for blanking
    set_mode(6'h00);
    blank_force = 1'b1;
    run_i2s(6'h00, 32);
    repeat (50) @(negedge clk);
    check("held_out_of_blank", {lv, 16'(rx_q.size())}, 64'h0);
    blank_val = 1'b1;
    drain(exp_cfg(6'h00));
    blank_force = 1'b0;
    // multiplexed frames: eight 32-bit then four 64-bit slots
    tdm_en = 1'b1;
    for (int e = 1; e >= 0; e--) begin
      tdm_eight = e[0];
      for (int i = 0; i < 8; i++) fr[i * 32 +: 32] = $urandom();
      // the frame-start select rise closes the zero lead-in as the last slot
      exp_q.push_back({32'h0, 2'h0, (e ? 3'h7 : 3'h3), 1'b1});
      for (int s = 0; s < (e ? 8 : 4); s++) begin
        exp_q.push_back({e ? fr[255 - 32 * s -: 32] : fr[255 - 64 * s -: 32], 2'h0, 3'(s), 1'b1});
      end
      src_u.tdm_frame($urandom_range(12, 5), fr);
      drain(exp_cfg(6'h00));
    end
    tdm_en = 1'b0;
    // fifo filled until it refuses, then drained, link stalled meanwhile
    do_reset();
    set_mode(6'h02);
    stall = 1'b1;
    blank_force = 1'b1;
    blank_val = 1'b1;
    repeat (3) run_i2s(6'h02, 32);
    repeat (20) @(negedge clk);
    check("overrun", ovr_o, 1'b1);
    stall = 1'b0;
    repeat (400) @(negedge clk);
    for (int i = 0; i < 16; i++) check("fifo_word", rx_q[i], exp_q[i]);
    check("overrun_sticky", ovr_o, 1'b1);
    do_reset();
    print_verdict();
  end

  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    print_verdict();
  end

endmodule : test_serializer_audio_input_transport
